// ### include/fpr_pkg.sv
// Shared constants and types for the flash parallel request port
package fpr_pkg;

  // Flash block geometry
  localparam int FLASH_ADDR_W = 9;
  localparam int FLASH_DATA_W = 16;
  localparam int FLASH_DEPTH = 512;
  localparam int SECTOR_BIT = 8;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // User width limits
  localparam int USER_ADDR_MIN = 3;
  localparam int USER_DATA_MIN = 3;

  // Input synchroniser reset values (strobes idle high)
  localparam logic [2:0] STROBES_IDLE = 3'h7;

  // Strobe vector bit positions
  localparam int STB_READ = 0;
  localparam int STB_WRITE = 1;
  localparam int STB_ERASE = 2;

  // Clock and timing
  localparam int CLK_NS = 4;
  localparam int T_BUSY_MAX_NS = 300;
  localparam int T_READ_NS = 100;
  localparam int T_WRITE_NS = 1000;
  localparam int T_ERASE_NS = 4000;
  localparam int T_BUSY_MAX_CYC = T_BUSY_MAX_NS / CLK_NS;
  localparam int T_READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WRITE_CYC = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W = 12;
  localparam int BITCNT_W = 4;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_ERASE = 2'b10
  } fpr_op_type;

endpackage

// ### include/fpr_flash_if.sv
// Request and answer signals between the port logic and the flash array
`timescale 1ns/1ps
interface fpr_flash_if;
  logic start;
  fpr_pkg::fpr_op_type op;
  logic [8:0] addr;
  logic [15:0] wdata;
  logic done;
  logic ser_bit;
  logic ser_valid;

  modport ctrl (
    output start,
    output op,
    output addr,
    output wdata,
    input done,
    input ser_bit,
    input ser_valid
  );

  modport array (
    input start,
    input op,
    input addr,
    input wdata,
    output done,
    output ser_bit,
    output ser_valid
  );
endinterface

// ### design/fpr_array.sv
// Flash array model: timed read, program and sector erase, serial readout
`timescale 1ns/1ps
module fpr_array (
  input wire logic clk,
  input wire logic rst_n,
  fpr_flash_if.array fl
);

  typedef enum logic [1:0] {
    A_IDLE = 2'b00,
    A_TIME = 2'b01,
    A_SHIFT = 2'b10
  } fpr_astate_type;

  localparam int TW = fpr_pkg::TIMER_W;
  localparam logic [TW-1:0] RD_CNT = TW'(fpr_pkg::T_READ_CYC - 1);
  localparam logic [TW-1:0] WR_CNT = TW'(fpr_pkg::T_WRITE_CYC - 1);
  localparam logic [TW-1:0] ER_CNT = TW'(fpr_pkg::T_ERASE_CYC - 1);

  fpr_astate_type state_reg;
  fpr_astate_type state_next;
  fpr_pkg::fpr_op_type op_reg;
  logic [8:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [TW-1:0] timer_reg;
  logic [15:0] shift_reg;
  logic [3:0] bitcnt_reg;
  logic done_reg;
  logic [15:0] mem [0:fpr_pkg::FLASH_DEPTH-1];
  logic [fpr_pkg::FLASH_DEPTH-1:0] written_reg;

  wire timer_zero = (timer_reg == '0);
  wire op_end = (state_reg == A_TIME) && timer_zero;
  wire write_fire = op_end && (op_reg == fpr_pkg::OP_WRITE);
  wire erase_fire = op_end && (op_reg == fpr_pkg::OP_ERASE);
  wire read_fire = op_end && (op_reg == fpr_pkg::OP_READ);
  wire erase_sector = addr_reg[fpr_pkg::SECTOR_BIT];
  // Unprogrammed words read as erased, so no memory reset is needed
  wire [15:0] cur_word = written_reg[addr_reg] ? mem[addr_reg]
                                               : fpr_pkg::ERASED_WORD;
  wire [TW-1:0] start_cnt = (fl.op == fpr_pkg::OP_READ) ? RD_CNT :
                            (fl.op == fpr_pkg::OP_WRITE) ? WR_CNT : ER_CNT;

  assign fl.done = done_reg;
  assign fl.ser_valid = (state_reg == A_SHIFT);
  assign fl.ser_bit = shift_reg[15];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      A_IDLE: if (fl.start) state_next = A_TIME;
      A_TIME: begin
        if (read_fire) state_next = A_SHIFT;
        else if (op_end) state_next = A_IDLE;
      end
      A_SHIFT: if (bitcnt_reg == '0) state_next = A_IDLE;
      default: state_next = A_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= A_IDLE;
      op_reg <= fpr_pkg::OP_READ;
      addr_reg <= '0;
      wdata_reg <= '0;
      timer_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      done_reg <= (op_end && !read_fire) ||
                  (state_reg == A_SHIFT && bitcnt_reg == '0);
      if (state_reg == A_IDLE && fl.start) begin
        op_reg <= fl.op;
        addr_reg <= fl.addr;
        wdata_reg <= fl.wdata;
        timer_reg <= start_cnt;
      end else if (!timer_zero) begin
        timer_reg <= timer_reg - TW'(1);
      end
    end
  end

  // Read register is shifted out MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      bitcnt_reg <= '0;
    end else if (read_fire) begin
      shift_reg <= cur_word;
      bitcnt_reg <= 4'hF;
    end else if (state_reg == A_SHIFT) begin
      shift_reg <= {shift_reg[14:0], 1'b1};
      bitcnt_reg <= bitcnt_reg - 4'h1;
    end
  end

  // Programming can only clear bits, as in real flash
  always_ff @(posedge clk) begin
    if (write_fire) mem[addr_reg] <= cur_word & wdata_reg;
  end

  genvar gi;
  generate
    for (gi = 0; gi < fpr_pkg::FLASH_DEPTH; gi++) begin : g_word
      localparam logic [8:0] IDX = 9'(gi);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          written_reg[gi] <= 1'b0;
        end else if (erase_fire &&
                     IDX[fpr_pkg::SECTOR_BIT] == erase_sector) begin
          written_reg[gi] <= 1'b0;
        end else if (write_fire && addr_reg == IDX) begin
          written_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule

// ### design/fpr_port.sv
// Top level of the flash parallel request port
`timescale 1ns/1ps
module fpr_port #(
  parameter int ADDR_W = fpr_pkg::FLASH_ADDR_W,
  parameter int DATA_W = fpr_pkg::FLASH_DATA_W,
  parameter bit READ_ONLY = 1'b0
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic READ_N,
  input wire logic WRITE_N,
  input wire logic ERASE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WRITE_WORD_IN,
  output logic [DATA_W-1:0] READ_WORD_OUT,
  output logic BUSY_N,
  output logic DATA_VALID,
  output logic OSCILLATOR_ON
);

  localparam int FAW = fpr_pkg::FLASH_ADDR_W;
  localparam int FDW = fpr_pkg::FLASH_DATA_W;
  localparam int IN_W = 3 + ADDR_W + DATA_W;
  localparam logic [IN_W-1:0] IN_IDLE =
    {fpr_pkg::STROBES_IDLE, {(ADDR_W + DATA_W){1'b0}}};
  localparam logic [FDW-1:0] LOW_ONES = {FDW{1'b1}} >> DATA_W;
  localparam logic [2:0] ALLOWED = READ_ONLY ? 3'h1 : 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } fpr_state_type;

  localparam int APAD = FAW - ADDR_W;
  localparam int DPAD = FDW - DATA_W;

  fpr_flash_if fl ();

  // Pin side: strobes, address and data all pass the same two stages,
  // so the operands seen with a strobe edge are never older than the edge
  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic [2:0] prev_stb_reg;

  fpr_state_type state_reg;
  fpr_state_type state_next;
  logic start_reg;
  fpr_pkg::fpr_op_type op_reg;
  logic [FAW-1:0] addr_reg;
  logic [FDW-1:0] wdata_reg;
  logic [FDW-1:0] collect_reg;
  logic [DATA_W-1:0] read_word_reg;
  logic busy_n_reg;
  logic valid_reg;
  logic osc_on_reg;

  // Synchronised view of the pins
  wire [IN_W-1:0] pins_in = {ERASE_N, WRITE_N, READ_N, ADDR, WRITE_WORD_IN};
  wire [2:0] stb_n_s = sync2_reg[IN_W-1 -: 3];
  wire [ADDR_W-1:0] addr_s = sync2_reg[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] wdata_s = sync2_reg[DATA_W-1:0];
  wire [2:0] stb_low = ~stb_n_s;

  // A request starts only on a fall from the all-idle level; a strobe
  // still held low after its operation ends cannot start a second one
  wire stb_fell = (prev_stb_reg == fpr_pkg::STROBES_IDLE) &&
                  (stb_low != 3'h0);
  wire one_low = (stb_low == 3'h1) ||
                 (stb_low == 3'h2) ||
                 (stb_low == 3'h4);
  wire allowed = (stb_low & ~ALLOWED) == 3'h0;
  wire idle = (state_reg == ST_IDLE);
  wire accept = idle && stb_fell && one_low && allowed;
  wire run_end = (state_reg == ST_RUN) && fl.done;
  wire read_end = run_end && (op_reg == fpr_pkg::OP_READ);

  // Operation chosen by the single low strobe
  fpr_pkg::fpr_op_type req_op;
  assign req_op = stb_low[fpr_pkg::STB_WRITE] ? fpr_pkg::OP_WRITE :
                  stb_low[fpr_pkg::STB_ERASE] ? fpr_pkg::OP_ERASE :
                  fpr_pkg::OP_READ;

  // Narrow user buses sit in the upper bits of the flash words
  wire [FAW-1:0] addr_full = FAW'(addr_s) << APAD;
  wire [FDW-1:0] wdata_full =
    (FDW'(wdata_s) << DPAD) | LOW_ONES;

  // Requests and operands towards the array
  assign fl.start = start_reg;
  assign fl.op = op_reg;
  assign fl.addr = addr_reg;
  assign fl.wdata = wdata_reg;

  fpr_array arr_u (
    .clk(MCLK),
    .rst_n(RSTN),
    .fl(fl)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fl.done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Two-stage synchroniser and the strobe history for edge detection
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= IN_IDLE;
      sync2_reg <= IN_IDLE;
      prev_stb_reg <= fpr_pkg::STROBES_IDLE;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      prev_stb_reg <= stb_n_s;
    end
  end

  // Operands are captured at acceptance, so later pin changes are harmless
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      start_reg <= 1'b0;
      op_reg <= fpr_pkg::OP_READ;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      start_reg <= accept;
      if (accept) begin
        op_reg <= req_op;
        addr_reg <= addr_full;
        wdata_reg <= wdata_full;
      end
    end
  end

  // Serial readout of the array arrives MSB first
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      collect_reg <= '0;
    end else if (fl.ser_valid) begin
      collect_reg <= {collect_reg[FDW-2:0], fl.ser_bit};
    end
  end

  // Busy output
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      busy_n_reg <= 1'b1;
    end else if (accept) begin
      busy_n_reg <= 1'b0;
    end else if (run_end) begin
      busy_n_reg <= 1'b1;
    end
  end

  // Read result and its valid flag
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      valid_reg <= 1'b0;
      read_word_reg <= '0;
    end else if (accept) begin
      valid_reg <= 1'b0;
    end else if (read_end) begin
      valid_reg <= 1'b1;
      read_word_reg <= collect_reg[FDW-1 -: DATA_W];
    end
  end

  // The oscillator is never switched off, even in the read-only build
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      osc_on_reg <= 1'b1;
    end else begin
      osc_on_reg <= 1'b1;
    end
  end

  assign READ_WORD_OUT = read_word_reg;
  assign BUSY_N = busy_n_reg;
  assign DATA_VALID = valid_reg;
  assign OSCILLATOR_ON = osc_on_reg;

endmodule

// ### verification/fpr_port_monitor.sv
// Port checker for the flash request port
`timescale 1ns/1ps
module fpr_port_monitor #(
  parameter int DATA_W = 16
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic READ_N,
  input wire logic WRITE_N,
  input wire logic ERASE_N,
  input wire logic [DATA_W-1:0] READ_WORD_OUT,
  input wire logic BUSY_N,
  input wire logic DATA_VALID,
  input wire logic OSCILLATOR_ON
);
  logic [1:0] nlow;
  logic [11:0] busy_cnt_reg;
  assign nlow = 2'(!READ_N) + 2'(!WRITE_N) + 2'(!ERASE_N);
  // Longest legal busy is an erase of 1000 cycles
  always_ff @(posedge MCLK or negedge RSTN)
    if (!RSTN) busy_cnt_reg <= 12'h000;
    else busy_cnt_reg <= BUSY_N ? 12'h000 : busy_cnt_reg + 12'h001;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  AST_OSC_ON: assert property (OSCILLATOR_ON)
    else $error("osc off");
  AST_BUSY_FALL: assert property (BUSY_N && nlow == 2'h1 &&
    $past(nlow) == 2'h0 |-> ##[0:75] !BUSY_N) else $error("busy late");
  AST_MULTI: assert property ($past(nlow) == 2'h0 &&
    nlow > 2'h1 && BUSY_N |-> BUSY_N[*8]) else $error("multi taken");
  AST_BUSY_BOUND: assert property (busy_cnt_reg < 12'h44C)
    else $error("busy stuck");
  AST_RESET_IDLE: assert property ($rose(RSTN) |-> BUSY_N)
    else $error("busy at reset");
  AST_VALID_RISE: assert property (
    $rose(DATA_VALID) |-> ##[0:2] BUSY_N) else $error("valid early");
  AST_VALID_HOLD: assert property (DATA_VALID && $past(DATA_VALID)
    |-> $stable(READ_WORD_OUT)) else $error("data moved");
  AST_VALID_CLR: assert property (!BUSY_N[*3] |-> !DATA_VALID)
    else $error("valid in busy");
  COV_READ: cover property ($rose(DATA_VALID));
  COV_MULTI: cover property (nlow > 2'h1);
  COV_BUSY: cover property ($fell(BUSY_N));
endmodule
bind fpr_port fpr_port_monitor #(.DATA_W(DATA_W)) mon_u (
  .MCLK(MCLK), .RSTN(RSTN), .READ_N(READ_N), .WRITE_N(WRITE_N),
  .ERASE_N(ERASE_N), .READ_WORD_OUT(READ_WORD_OUT), .BUSY_N(BUSY_N),
  .DATA_VALID(DATA_VALID), .OSCILLATOR_ON(OSCILLATOR_ON));

// ### verification/fpr_requester.sv
// Requester model: strobes, address and write data
`timescale 1ns/1ps
module fpr_requester (
  input wire logic clk,
  output logic [2:0] stb_n,
  output logic [8:0] addr,
  output logic [15:0] wdata
);
  initial begin
    stb_n = 3'h7;
    addr = 9'h000;
    wdata = 16'h0000;
  end
  // 200 cycles is 800 ns, inside the legal strobe window
  task automatic req(input logic [2:0] low, input logic [8:0] a,
    input logic [15:0] d);
    @(posedge clk);
    stb_n <= ~low;
    addr <= a;
    wdata <= d;
    repeat (200) @(posedge clk);
    stb_n <= 3'h7;
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the flash request port
`timescale 1ns/1ps
module tb_top;
  logic MCLK, RSTN, busy_n, valid, osc;
  logic [2:0] stb_n;
  logic [8:0] addr;
  logic [15:0] wdata, rdata;
  int bad_count, checks, cyc;
  fpr_requester req_u (.clk(MCLK), .stb_n(stb_n), .addr(addr),
    .wdata(wdata));
  fpr_port dut_u (.MCLK(MCLK), .RSTN(RSTN), .READ_N(stb_n[0]),
    .WRITE_N(stb_n[1]), .ERASE_N(stb_n[2]), .ADDR(addr),
    .WRITE_WORD_IN(wdata), .READ_WORD_OUT(rdata), .BUSY_N(busy_n),
    .DATA_VALID(valid), .OSCILLATOR_ON(osc));
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d bad=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic op(input logic [2:0] low, input logic [8:0] a,
    input logic [15:0] d);
    int n = 0;
    req_u.req(low, a, d);
    while (busy_n !== 1'b1 && n < 1200) begin
      @(posedge MCLK);
      n++;
    end
    @(posedge MCLK);
    #1;
    check(16'(busy_n), 16'h0001);
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    op(3'h1, a, 16'h0000);
    check(16'(valid), 16'h0001);
    check(rdata, exp);
  endtask
  task automatic t_write_read;
    op(3'h2, 9'h1A5, 16'hA55A);
    rd(9'h1A5, 16'hA55A);
    $display("write_read done");
  endtask
  task automatic t_erase;
    op(3'h2, 9'h005, 16'h1234);
    op(3'h4, 9'h100, 16'h0000);
    rd(9'h1A5, fpr_pkg::ERASED_WORD);
    rd(9'h005, 16'h1234);
    $display("erase done");
  endtask
  task automatic t_multi;
    op(3'h3, 9'h005, 16'h0000);
    op(3'h6, 9'h005, 16'h0000);
    rd(9'h005, 16'h1234);
    $display("multi done");
  endtask
  task automatic t_busy;
    req_u.req(3'h2, 9'h006, 16'h0BEE);
    // Read strobe falls while the write still holds busy low
    op(3'h1, 9'h006, 16'h0000);
    check(16'(valid), 16'h0000);
    rd(9'h006, 16'h0BEE);
    $display("busy done");
  endtask
  initial begin
    RSTN = 1'b0;
    repeat (3) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (2) @(posedge MCLK);
    #1;
    check(16'(osc), 16'h0001);
    t_write_read;
    t_erase;
    t_multi;
    t_busy;
    conclude;
  end
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      conclude;
    end
  end
endmodule
